// *** common/delay_if.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Link between the sequencer and its delay timer
// ---------------------------------------------------------------------------
interface delay_if;
   logic       start;    // Loads and starts the timer.
   logic [2:0] exp;      // Delay code, read while start is high.
   logic       expired;  // One-cycle pulse when the delay has run out.

   modport ctrl  (output start, output exp, input expired);
   modport timer (input start, input exp, output expired);
endinterface

// *** common/ot_fault_pkg.sv ***
// ---------------------------------------------------------------------------
// Shared constants and types of the over-temperature fault response
// ---------------------------------------------------------------------------
package ot_fault_pkg;

   // Command code under which the fault action setting is reached.
   localparam logic [7:0] CMD_OT_FAULT_ACTION = 8'h50;
   // Value the fault action setting takes at reset.
   localparam logic [7:0] ACTION_RESET        = 8'h80;

   // Field positions inside the fault action setting.
   localparam int RESP_MSB  = 7;
   localparam int RESP_LSB  = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;

   // Encodings of the response field.
   localparam logic [1:0] RESP_IGNORE        = 2'h0;
   localparam logic [1:0] RESP_DELAYED       = 2'h1;
   localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
   localparam logic [1:0] RESP_LATCH         = 2'h3;

   // Encodings of the retry field.
   localparam logic [2:0] RETRY_NONE    = 3'h0;
   localparam logic [2:0] RETRY_ENDLESS = 3'h7;

   // Width of the delay counter; the longest delay is 128 units.
   localparam int         DELAY_CNT_W = 8;
   localparam logic [7:0] DELAY_ONE   = 8'h01;

   // States of the fault response sequencer.
   typedef enum logic [2:0]
   {
      ST_RUN,
      ST_GRACE,
      ST_WAIT,
      ST_TRY,
      ST_LATCHED
   } fsm_t;

endpackage

// *** src/delay_timer.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Power-of-two delay timer counted in external time units
// ---------------------------------------------------------------------------
module delay_timer
   import ot_fault_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic unit_tick,
   delay_if.timer    tmr
);

   // All timer state in one record.
   typedef struct packed
   {
      logic [DELAY_CNT_W-1:0] cnt;      // Units still to run.
      logic                   running;  // Timer is counting.
      logic                   expired;  // Expiry pulse.
   } tmr_state_t;

   tmr_state_t s_q;  // Registered state.
   tmr_state_t s_d;  // Next state.

   // Next-state logic: a start reloads 2**code units, which also restarts
   // a running delay; otherwise each unit tick counts a running delay one unit down.
   always_comb
   begin
      s_d         = s_q;
      s_d.expired = 1'b0;
      if (tmr.start)
      begin
         s_d.cnt     = DELAY_ONE << tmr.exp;
         s_d.running = 1'b1;
      end
      else if (s_q.running && unit_tick)
      begin
         // The last unit ends the delay with a single pulse.
         if (s_q.cnt == DELAY_ONE)
         begin
            s_d.running = 1'b0;
            s_d.expired = 1'b1;
         end
         s_d.cnt = s_q.cnt - DELAY_ONE;
      end
   end

   // State register.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign tmr.expired = s_q.expired;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   a_load_pow2: assert property (@(posedge core_clk) disable iff (rst)
      tmr.start |=> s_q.cnt == (DELAY_ONE << $past(tmr.exp)))
      else $error("Delay not loaded as a power of two.");

   a_expire_unit: assert property (@(posedge core_clk) disable iff (rst)
      s_q.expired |-> $past(unit_tick) && !$past(tmr.start))
      else $error("Delay expired without a time unit.");

endmodule

// *** src/over_temp_fault_action.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Over-temperature fault response sequencer
// ---------------------------------------------------------------------------
module over_temp_fault_action
   import ot_fault_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       over_temp_raw,
   input  wire logic       on_cmd_raw,
   input  wire logic       unit_tick,
   input  wire logic [7:0] cmd_code,
   input  wire logic       cmd_wr,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic       cmd_rd,
   input  wire logic       clear_faults,
   input  wire logic       clear_fault_bit,
   output logic      [7:0] cmd_rdata,
   output logic            output_enable,
   output logic            fault_status,
   output logic            alert_line_n_out,
   output logic            alert_line_n_oe
);

   // -----------------------------------------------------------------------
   // State record
   // -----------------------------------------------------------------------
   typedef struct packed
   {
      logic       ot_meta;    // Fault input, first sync stage.
      logic       ot_s;       // Fault input, synchronised.
      logic       on_meta;    // On command, first sync stage.
      logic       on_s;       // On command, synchronised.
      logic [7:0] action;     // Fault action setting.
      logic [7:0] rdata;      // Read data.
      logic       status;     // Sticky fault status bit.
      logic       out_on;     // Output enable.
      logic [2:0] tries;      // Restart attempts still allowed.
      fsm_t       st;         // Sequencer state.
   } ctl_state_t;

   ctl_state_t s_q;  // Registered state.
   ctl_state_t s_d;  // Next state.

   delay_if    dly ();  // Link to the delay timer.

   logic [1:0] resp;       // Response field.
   logic [2:0] retry;      // Retry field.
   logic       fault;      // Fault present, synchronised.
   logic       on;         // Output commanded on, synchronised.
   logic       clear_req;  // Any software clear of the fault.

   assign resp      = s_q.action[RESP_MSB:RESP_LSB];
   assign retry     = s_q.action[RETRY_MSB:RETRY_LSB];
   assign fault     = s_q.ot_s;
   assign on        = s_q.on_s;
   assign clear_req = clear_faults | clear_fault_bit;
   assign dly.exp   = s_q.action[DELAY_MSB:DELAY_LSB];

   // -----------------------------------------------------------------------
   // Delay timer
   // -----------------------------------------------------------------------
   delay_timer u_timer
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .unit_tick (unit_tick),
      .tmr       (dly)
   );

   // -----------------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------------
   // Synchronises the pins, serves the setting, keeps the status bit and
   // steps the sequencer. A shutdown with no retries latches off; with
   // retries it waits one interval, then tries again.
   always_comb
   begin
      s_d         = s_q;
      dly.start   = 1'b0;
      s_d.ot_meta = over_temp_raw;
      s_d.ot_s    = s_q.ot_meta;
      s_d.on_meta = on_cmd_raw;
      s_d.on_s    = s_q.on_meta;

      // Setting write; unmapped codes are ignored.
      if (cmd_wr && cmd_code == CMD_OT_FAULT_ACTION)
         s_d.action = cmd_wdata;

      // Setting read; unmapped codes read as zero.
      if (cmd_rd && cmd_code == CMD_OT_FAULT_ACTION)
         s_d.rdata = s_q.action;
      else if (cmd_rd)
         s_d.rdata = 8'h00;

      // Status bit: a present fault wins over a clear in the same cycle.
      if (fault)
         s_d.status = 1'b1;
      else if (clear_req)
         s_d.status = 1'b0;

      if (!on)
      begin
         // Commanded off: output off, any retry or latch ends here.
         s_d.out_on = 1'b0;
         s_d.st     = ST_RUN;
      end
      else
      begin
         case (s_q.st)
            ST_RUN:
            begin
               s_d.out_on = 1'b1;
               if (fault)
               begin
                  case (resp)
                     RESP_IGNORE:
                        s_d.out_on = 1'b1;
                     RESP_DELAYED:
                     begin
                        dly.start = 1'b1;
                        s_d.st    = ST_GRACE;
                     end
                     RESP_DISABLE_RETRY:
                     begin
                        s_d.out_on = 1'b0;
                        if (retry == RETRY_NONE)
                           s_d.st = ST_LATCHED;
                        else
                        begin
                           dly.start = 1'b1;
                           s_d.tries = retry;
                           s_d.st    = ST_WAIT;
                        end
                     end
                     default:
                     begin
                        s_d.out_on = 1'b0;
                        s_d.st     = ST_LATCHED;
                     end
                  endcase
               end
            end
            ST_GRACE:
            begin
               // Output keeps running through the grace delay.
               s_d.out_on = 1'b1;
               if (dly.expired && fault)
               begin
                  s_d.out_on = 1'b0;
                  if (retry == RETRY_NONE)
                     s_d.st = ST_LATCHED;
                  else
                  begin
                     dly.start = 1'b1;
                     s_d.tries = retry;
                     s_d.st    = ST_WAIT;
                  end
               end
               else if (dly.expired)
                  s_d.st = ST_RUN;
            end
            ST_WAIT:
            begin
               s_d.out_on = 1'b0;
               if (dly.expired && s_q.tries == RETRY_NONE)
                  s_d.st = ST_LATCHED;
               else if (dly.expired)
               begin
                  // New attempt; the next one is spaced from its start.
                  s_d.out_on = 1'b1;
                  dly.start  = 1'b1;
                  if (s_q.tries != RETRY_ENDLESS)
                     s_d.tries = s_q.tries - 3'h1;
                  s_d.st = ST_TRY;
               end
            end
            ST_TRY:
            begin
               s_d.out_on = 1'b1;
               if (fault)
               begin
                  // Attempt failed: off for the rest of the interval.
                  s_d.out_on = 1'b0;
                  s_d.st     = ST_WAIT;
                  // An interval ending now starts the next one at once,
                  // so the wait state is never left without a timer.
                  if (dly.expired)
                     dly.start = 1'b1;
               end
               else if (dly.expired)
                  s_d.st = ST_RUN;
            end
            default:
            begin
               // Latched off; while commanded on, only a clear releases it.
               s_d.out_on = 1'b0;
               if (clear_req)
                  s_d.st = ST_RUN;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q        <= '0;
         s_q.action <= ACTION_RESET;
         s_q.st     <= ST_RUN;
      end
      else
         s_q <= s_d;
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   assign cmd_rdata        = s_q.rdata;
   assign output_enable    = s_q.out_on;
   assign fault_status     = s_q.status;
   assign alert_line_n_out = 1'b0;
   assign alert_line_n_oe  = s_q.status;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   a_ignore_runs: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_RUN && on && fault && resp == RESP_IGNORE
      |=> s_q.out_on && s_q.st == ST_RUN)
      else $error("Ignored fault interrupted the output.");

   a_grace_on: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_GRACE |-> s_q.out_on)
      else $error("Output off during grace delay.");

   a_grace_end: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_GRACE && dly.expired && fault && on
      |=> !s_q.out_on)
      else $error("Fault persisting after grace did not stop output.");

   a_disable_now: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_RUN && on && fault && resp == RESP_DISABLE_RETRY
      |=> !s_q.out_on)
      else $error("Output not disabled at once.");

   a_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_LATCHED && !clear_req && on
      |=> s_q.st == ST_LATCHED && !s_q.out_on)
      else $error("Latched shutdown released without a clear.");

   a_no_retry: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_RUN && on && fault
      && resp == RESP_DISABLE_RETRY && retry == RETRY_NONE
      |=> s_q.st == ST_LATCHED)
      else $error("Retry code zero did not latch off.");

   a_tries_out: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_WAIT && dly.expired && on && s_q.tries == RETRY_NONE
      |=> s_q.st == ST_LATCHED ##1 !s_q.out_on)
      else $error("Restart made after attempts ran out.");

   a_try_spacing: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_WAIT && dly.expired && on && s_q.tries != RETRY_NONE
      |-> dly.start ##1 s_q.out_on)
      else $error("Attempt did not restart its interval.");

   a_endless: assert property (@(posedge core_clk) disable iff (rst)
      s_q.st == ST_WAIT && dly.expired && on
      && s_q.tries == RETRY_ENDLESS
      |=> s_q.st == ST_TRY && s_q.tries == RETRY_ENDLESS)
      else $error("Endless retry stopped counting wrong.");

   a_alert_low: assert property (@(posedge core_clk) disable iff (rst)
      fault |=> fault_status && alert_line_n_oe)
      else $error("Fault did not raise status and alert.");

endmodule

// *** verification/host_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Management host that writes and reads the fault setting and clears faults
// ---------------------------------------------------------------------------
module host_model (
   input  wire logic       core_clk,
   output logic      [7:0] cmd_code,
   output logic            cmd_wr,
   output logic      [7:0] cmd_wdata,
   output logic            cmd_rd,
   output logic            clear_faults,
   output logic            clear_fault_bit
);
   // All lines start idle so that nothing is requested during reset.
   initial
   begin
      cmd_code        = 8'h00;
      cmd_wr          = 1'b0;
      cmd_wdata       = 8'h00;
      cmd_rd          = 1'b0;
      clear_faults    = 1'b0;
      clear_fault_bit = 1'b0;
   end

   // One access: held for one edge, then the data lines show a new value.
   task automatic access(input logic wr, input logic [7:0] code,
                         input logic [7:0] data);
      @(posedge core_clk);
      cmd_code  <= code;
      cmd_wdata <= data;
      cmd_wr    <= wr;
      cmd_rd    <= ~wr;
      @(posedge core_clk);
      cmd_wr    <= 1'b0;
      cmd_rd    <= 1'b0;
      cmd_wdata <= ~data;
      cmd_code  <= ~code;
   endtask

   // One clear pulse; which selects the bit clear over the global one.
   task automatic clear(input logic which);
      @(posedge core_clk);
      clear_faults    <= ~which;
      clear_fault_bit <= which;
      @(posedge core_clk);
      clear_faults    <= 1'b0;
      clear_fault_bit <= 1'b0;
   endtask
endmodule

// *** verification/over_temp_fault_action_bench.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Self-checking bench of the over-temperature fault response
// ---------------------------------------------------------------------------
module over_temp_fault_action_bench;
   import ot_fault_pkg::*;
   logic       core_clk;          // Core clock.
   logic       rst;               // Reset, active high.
   logic       over_temp_raw;     // Fault input.
   logic       on_cmd_raw;        // Output on command.
   logic       unit_tick;         // Delay unit pulse.
   logic [7:0] cmd_code;          // Host command code.
   logic       cmd_wr;            // Host write strobe.
   logic [7:0] cmd_wdata;         // Host write data.
   logic       cmd_rd;            // Host read strobe.
   logic       clear_faults;      // Global clear pulse.
   logic       clear_fault_bit;   // Bit clear pulse.
   logic [7:0] cmd_rdata;         // Read data.
   logic       output_enable;     // Converter output on.
   logic       fault_status;      // Sticky fault bit.
   logic       alert_line_n_out;  // Alert drive level.
   logic       alert_line_n_oe;   // Alert drive enable.
   int         n_errors = 0;      // Mismatches seen.
   int         total_checks = 0;  // Comparisons made.
   int         cycles = 0;        // Clock cycles run.
   int         n_ticks = 0;       // Units handed out.
   int         n_rises = 0;       // Output turn-on events.
   int         last_rise = 0;     // Unit count at the last turn-on.
   int         gap = 0;           // Units between the last two turn-ons.
   int         base;              // Turn-on count at scenario start.
   logic       oe_prev = 1'b0;    // Output level one cycle back.

   // The clock toggles every half period of 5 ns.
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   over_temp_fault_action i_dut (.core_clk(core_clk), .rst(rst),
      .over_temp_raw(over_temp_raw), .on_cmd_raw(on_cmd_raw),
      .unit_tick(unit_tick), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .clear_faults(clear_faults),
      .clear_fault_bit(clear_fault_bit), .cmd_rdata(cmd_rdata),
      .output_enable(output_enable), .fault_status(fault_status),
      .alert_line_n_out(alert_line_n_out),
      .alert_line_n_oe(alert_line_n_oe));

   host_model i_host (.core_clk(core_clk), .cmd_code(cmd_code),
      .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd),
      .clear_faults(clear_faults), .clear_fault_bit(clear_fault_bit));

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   // Counts turn-ons of the output and the unit spacing between them.
   always @(posedge core_clk)
   begin
      oe_prev <= output_enable;
      if (output_enable === 1'b1 && oe_prev === 1'b0)
      begin
         n_rises   <= n_rises + 1;
         gap       <= n_ticks - last_rise;
         last_rise <= n_ticks;
      end
   end

   // Ends the run with the verdict.
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A hang counts as a mismatch and closes the run.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         n_errors++;
         end_sim();
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Waits a number of cycles.
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Hands out n delay units, each followed by settling cycles.
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         unit_tick <= 1'b1;
         n_ticks++;
         @(posedge core_clk);
         unit_tick <= 1'b0;
         cyc(2);
      end
   endtask

   // Reads a command code and compares the answer.
   task automatic rd(input logic [7:0] code, input logic [7:0] exp);
      i_host.access(1'b0, code, 8'h00);
      // Read data stand from the edge that took the strobe onwards.
      @(posedge core_clk);
      chk("rdata", exp, cmd_rdata);
   endtask

   // Removes the fault, clears it and expects the output back on.
   task automatic recover(input logic which);
      over_temp_raw <= 1'b0;
      cyc(4);
      i_host.clear(which);
      cyc(5);
      chk("oe_back", 8'h01, 8'(output_enable));
   endtask

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      over_temp_raw = 1'b0;
      on_cmd_raw = 1'b0;
      unit_tick = 1'b0;
      cyc(3);
      rst <= 1'b0;
      rd(CMD_OT_FAULT_ACTION, ACTION_RESET);
      rd(8'h51, 8'h00);
      i_host.access(1'b1, 8'h51, 8'h3c);
      rd(CMD_OT_FAULT_ACTION, ACTION_RESET);
      on_cmd_raw <= 1'b1;
      cyc(5);
      chk("oe_on", 8'h01, 8'(output_enable));
      // Ignore mode keeps the output on but still raises the alert.
      i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'h00);
      over_temp_raw <= 1'b1;
      cyc(5);
      chk("oe_ign", 8'h01, 8'(output_enable));
      chk("status", 8'h01, 8'(fault_status));
      chk("alert", 8'h01, {7'h00, alert_line_n_oe});
      chk("alert_lvl", 8'h00, 8'(alert_line_n_out));
      over_temp_raw <= 1'b0;
      cyc(4);
      i_host.clear(1'b1);
      cyc(3);
      chk("status_clr", 8'h00, 8'(fault_status));
      chk("alert_clr", 8'h00, 8'(alert_line_n_oe));
      // Disable with no retry stays off after the fault leaves.
      i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'h80);
      over_temp_raw <= 1'b1;
      cyc(4);
      chk("oe_dis", 8'h00, 8'(output_enable));
      over_temp_raw <= 1'b0;
      tick(4);
      chk("oe_stay", 8'h00, 8'(output_enable));
      recover(1'b0);
      // Latch mode released by global clear, bit clear and off then on.
      for (int k = 0; k < 3; k++)
      begin
         i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'hc0);
         over_temp_raw <= 1'b1;
         cyc(4);
         over_temp_raw <= 1'b0;
         tick(3);
         chk("oe_latch", 8'h00, 8'(output_enable));
         if (k < 2)
            i_host.clear(k[0]);
         else
         begin
            on_cmd_raw <= 1'b0;
            cyc(4);
            on_cmd_raw <= 1'b1;
         end
         cyc(5);
         chk("oe_unlatch", 8'h01, 8'(output_enable));
      end
      // Grace time lasts exactly two to the power of the delay code.
      for (int d = 0; d < 8; d++)
      begin
         i_host.access(1'b1, CMD_OT_FAULT_ACTION, {5'b01000, 3'(d)});
         over_temp_raw <= 1'b1;
         cyc(4);
         tick((1 << d) - 1);
         chk("oe_grace", 8'h01, 8'(output_enable));
         tick(1);
         chk("oe_expire", 8'h00, 8'(output_enable));
         recover(1'b0);
      end
      // A fault gone before the grace ends leaves the output on.
      i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'h41);
      over_temp_raw <= 1'b1;
      cyc(4);
      tick(1);
      over_temp_raw <= 1'b0;
      tick(4);
      chk("oe_gone", 8'h01, 8'(output_enable));
      // Grace, then one retry; a fault gone by the attempt returns to run.
      i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'h48);
      base = n_rises;
      over_temp_raw <= 1'b1;
      cyc(4);
      tick(1);
      chk("oe_grace_off", 8'h00, 8'(output_enable));
      over_temp_raw <= 1'b0;
      tick(2);
      chk("oe_retry_ok", 8'h01, 8'(output_enable));
      chk("grace_tries", 8'h01, 8'(n_rises - base));
      // Limited retries: count of attempts and their spacing.
      for (int r = 1; r < 7; r++)
      begin
         i_host.access(1'b1, CMD_OT_FAULT_ACTION,
                       {2'b10, 3'(r), 3'(r % 3)});
         base = n_rises;
         over_temp_raw <= 1'b1;
         cyc(4);
         tick(8 << (r % 3));
         chk("tries", 8'(r), 8'(n_rises - base));
         if (r > 1)
            chk("spacing", 8'(1 << (r % 3)), 8'(gap));
         chk("oe_spent", 8'h00, 8'(output_enable));
         recover(1'b0);
      end
      // Endless retries go on while the fault stays; commanding the output off stops them.
      i_host.access(1'b1, CMD_OT_FAULT_ACTION, 8'hb8);
      rd(CMD_OT_FAULT_ACTION, 8'hb8);
      base = n_rises;
      over_temp_raw <= 1'b1;
      cyc(4);
      tick(20);
      // The last turn-on is counted at the edge that ends the ticks.
      cyc(1);
      chk("endless", 8'd20, 8'(n_rises - base));
      on_cmd_raw <= 1'b0;
      cyc(4);
      base = n_rises;
      tick(5);
      chk("off_stop", 8'h00, 8'(n_rises - base));
      chk("oe_off", 8'h00, 8'(output_enable));
      over_temp_raw <= 1'b0;
      on_cmd_raw <= 1'b1;
      cyc(5);
      chk("oe_final", 8'h01, 8'(output_enable));
      end_sim();
   end
endmodule
